// ### backplane_channel_control_regs.sv
// Purpose: Control registers of an eight-channel backplane transceiver core.
// Assumes: APB slave with 32-bit data, registers in the low byte, inputs synchronous to pclk.
// Notes: Every access takes one wait state; threshold alarms raise a level interrupt.
// Summary of operation
// - Pair-select bit 4 clear puts channel_b1 overhead on the channel_b0 serial output, set keeps its own, reset 1.
// - Pair-select bit 3 clear puts channel a3 parallel data on the channel_a2 output, set keeps its own, reset 1.
// - Pair-select bit 5 clear puts channel_b3 overhead on the channel_b2 serial output, set keeps its own, reset 1.
// - Pair-select bit 6 clear puts channel_b1 parallel data on the channel_b0 output, set keeps its own, reset 1.
// - Pair-select bit 7 clear puts channel_b3 parallel data on the channel_b2 output, set keeps its own, reset 1.
// - A channel whose alignment FIFO level falls below the minimum raises its alarm, latched when enabled.
// - The minimum threshold is one 5-bit field, msb at bit 4, shared by all channels; software keeps it in 1 to 23.
// - While a channel's insert command is active, its two framing bytes are replaced by the programmed values.
// - A 4-bit count, msb at bit 3, reset 0, sets how many consecutive frames are corrupted.
// - Loopback bit 4 set returns the recovered receive data to the transmit serializer; reset 0.
// - Bit 6 set enables receive descrambling and transmit scrambling; reset 1.
// - Two 8-bit registers hold the first_framing_byte and second_framing_byte substitutes, reset 0.
`timescale 1ns/1ps
module backplane_channel_control_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [39:0] fifo_level,
    output logic [7:0] threshold_alarm,
    input wire logic [7:0] toh_in,
    output logic [7:0] toh_out,
    input wire logic [63:0] par_in,
    output logic [63:0] par_out,
    output logic [7:0] par_parity,
    input wire logic [63:0] tx_data_in,
    input wire logic [7:0] tx_frame_start,
    input wire logic [7:0] tx_first_fb,
    input wire logic [7:0] tx_second_fb,
    output logic [63:0] tx_data_out,
    output logic loopback_en,
    output logic scramble_en,
    output logic parity_even
);

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave.
    backplane_ctrl_pkg::apb_state_e state_q;
    logic [19:0] idx;
    logic addr_ok;
    logic hit_sel, hit_min, hit_max, hit_ctrl, hit_fb1, hit_fb2;
    logic hit_cmd, hit_sts, hit_len, hit_msk;
    logic mapped;
    logic wr_en;
    logic [7:0] rd_val;
    logic [7:0] pair_sel_q, min_thr_q, max_thr_q, ctrl_q, fb1_q, fb2_q;
    logic [7:0] status_q, latch_en_q, irq_mask_q;
    logic [7:0] alarm_q;
    logic [7:0] ins_busy;
    logic [7:0] arm;
    logic [7:0] set_v;
    logic pready_q, pslverr_q, irq_q;
    logic [31:0] prdata_q;

    assign idx = paddr[21:2];
    assign addr_ok = (paddr[31:22] == 10'h000) && (paddr[1:0] == 2'h0);
    assign hit_sel = addr_ok && (idx == backplane_ctrl_pkg::IDX_PAIR_SEL);
    assign hit_min = addr_ok && (idx == backplane_ctrl_pkg::IDX_MIN_THR);
    assign hit_max = addr_ok && (idx == backplane_ctrl_pkg::IDX_MAX_THR);
    assign hit_ctrl = addr_ok && (idx == backplane_ctrl_pkg::IDX_CTRL);
    assign hit_fb1 = addr_ok && (idx == backplane_ctrl_pkg::IDX_FB1_VAL);
    assign hit_fb2 = addr_ok && (idx == backplane_ctrl_pkg::IDX_FB2_VAL);
    assign hit_cmd = addr_ok && (idx == backplane_ctrl_pkg::IDX_INS_CMD);
    assign hit_sts = addr_ok && (idx == backplane_ctrl_pkg::IDX_ALM_STATUS);
    assign hit_len = addr_ok && (idx == backplane_ctrl_pkg::IDX_ALM_LATCH_EN);
    assign hit_msk = addr_ok && (idx == backplane_ctrl_pkg::IDX_IRQ_MASK);
    assign mapped = hit_sel | hit_min | hit_max | hit_ctrl | hit_fb1 | hit_fb2 |
                    hit_cmd | hit_sts | hit_len | hit_msk;
    // A write lands only on the edge where the master sees pready, and only on lane 0.
    assign wr_en = psel && penable && pwrite && pready_q && mapped && pstrb[0];

    always_comb begin
        rd_val = 8'h00;
        if (hit_sel) rd_val = pair_sel_q;
        if (hit_min) rd_val = min_thr_q;
        if (hit_max) rd_val = max_thr_q;
        if (hit_ctrl) rd_val = ctrl_q;
        if (hit_fb1) rd_val = fb1_q;
        if (hit_fb2) rd_val = fb2_q;
        if (hit_cmd) rd_val = ins_busy;
        if (hit_sts) rd_val = status_q;
        if (hit_len) rd_val = latch_en_q;
        if (hit_msk) rd_val = irq_mask_q;
    end

    // The wait state keeps every output a flop at the cost of one cycle per access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= backplane_ctrl_pkg::APB_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            unique case (state_q)
                backplane_ctrl_pkg::APB_IDLE: begin
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                    if (psel && penable) begin
                        state_q <= backplane_ctrl_pkg::APB_ANSWER;
                        pready_q <= 1'b1;
                        pslverr_q <= !mapped;
                        prdata_q <= {24'h00_0000, pwrite ? 8'h00 : rd_val};
                    end
                end
                backplane_ctrl_pkg::APB_ANSWER: begin
                    state_q <= backplane_ctrl_pkg::APB_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                end
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_sel_q <= backplane_ctrl_pkg::RST_PAIR_SEL;
            min_thr_q <= backplane_ctrl_pkg::RST_MIN_THR;
            max_thr_q <= backplane_ctrl_pkg::RST_MAX_THR;
            ctrl_q <= backplane_ctrl_pkg::RST_CTRL;
            fb1_q <= backplane_ctrl_pkg::RST_ZERO;
            fb2_q <= backplane_ctrl_pkg::RST_ZERO;
            latch_en_q <= backplane_ctrl_pkg::RST_ZERO;
            irq_mask_q <= backplane_ctrl_pkg::RST_ZERO;
        end else if (wr_en) begin
            if (hit_sel) pair_sel_q <= pwdata[7:0];
            if (hit_min) min_thr_q <= pwdata[7:0];
            if (hit_max) max_thr_q <= pwdata[7:0];
            if (hit_ctrl) ctrl_q <= pwdata[7:0];
            if (hit_fb1) fb1_q <= pwdata[7:0];
            if (hit_fb2) fb2_q <= pwdata[7:0];
            if (hit_len) latch_en_q <= pwdata[7:0];
            if (hit_msk) irq_mask_q <= pwdata[7:0];
        end
    end

    assign loopback_en = ctrl_q[backplane_ctrl_pkg::CTRL_LOOPBACK];
    assign parity_even = ctrl_q[backplane_ctrl_pkg::CTRL_PARITY];
    assign scramble_en = ctrl_q[backplane_ctrl_pkg::CTRL_SCRAMBLE];

    ////////////////////////////////////////////////////////////////////////////////
    // Threshold alarms, sticky status and interrupt.
    // Software keeps min in 1..23 and max in 0..22; out of range values are compared as is.
    genvar c;
    generate
        for (c = 0; c < backplane_ctrl_pkg::NUM_CH; c++) begin : g_thr
            logic [4:0] lvl;
            assign lvl = fifo_level[c*5 +: 5];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    alarm_q[c] <= 1'b0;
                end else begin
                    alarm_q[c] <= (lvl < min_thr_q[backplane_ctrl_pkg::THR_MSB:0]) ||
                                  (lvl > max_thr_q[backplane_ctrl_pkg::THR_MSB:0]);
                end
            end
        end
    endgenerate

    assign threshold_alarm = alarm_q;
    assign set_v = alarm_q & latch_en_q;

    // A new alarm in the cycle of a write-one-to-clear keeps the bit set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 8'h00;
        end else begin
            status_q <= (status_q & ~((wr_en && hit_sts) ? pwdata[7:0] : 8'h00)) | set_v;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & irq_mask_q);
        end
    end

    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Framing-byte error insertion and output steering.
    assign arm = (wr_en && hit_cmd) ? pwdata[7:0] : 8'h00;

    generate
        for (c = 0; c < backplane_ctrl_pkg::NUM_CH; c++) begin : g_ins
            fb_error_insert u_ins (
                .pclk(pclk),
                .presetn(presetn),
                .arm(arm[c]),
                .count(ctrl_q[backplane_ctrl_pkg::CNT_MSB:0]),
                .fb1_val(fb1_q),
                .fb2_val(fb2_q),
                .data_in(tx_data_in[c*8 +: 8]),
                .frame_start(tx_frame_start[c]),
                .first_fb(tx_first_fb[c]),
                .second_fb(tx_second_fb[c]),
                .data_out_q(tx_data_out[c*8 +: 8]),
                .busy(ins_busy[c])
            );
        end
    endgenerate

    pair_output_select u_sel (
        .pclk(pclk),
        .presetn(presetn),
        .sel(pair_sel_q),
        .parity_even(parity_even),
        .toh_in(toh_in),
        .par_in(par_in),
        .toh_out_q(toh_out),
        .par_out_q(par_out),
        .par_parity_q(par_parity)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_q) |=> pready_q ##1 !pready_q)
        else $error("APB access not answered after one wait state");

    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_q && !mapped) |=> (pready_q && pslverr_q))
        else $error("Unmapped access not flagged");

    ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_ctrl) |=> (ctrl_q == $past(pwdata[7:0]) && loopback_en == $past(pwdata[4])))
        else $error("Control write not taken");

    toh_steer_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pair_sel_q[backplane_ctrl_pkg::SEL_TOH_B01] |=> (toh_out[4] == $past(toh_in[5])))
        else $error("Overhead of b1 not steered onto b0");

    par_steer_a: assert property (@(posedge pclk) disable iff (!presetn)
        pair_sel_q[backplane_ctrl_pkg::SEL_PAR_A23] |=> (par_out[23:16] == $past(par_in[23:16])))
        else $error("Channel a2 lost its own data");

    par_b23_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pair_sel_q[backplane_ctrl_pkg::SEL_PAR_B23] |=> (par_out[55:48] == $past(par_in[63:56])))
        else $error("Data of b3 not steered onto b2");

    // Only the even channels can be steered; the odd ones always pass straight through.
    toh_b23_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pair_sel_q[backplane_ctrl_pkg::SEL_TOH_B23] |=> (toh_out[6] == $past(toh_in[7])))
        else $error("Overhead of b3 not steered onto b2");

    par_b01_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pair_sel_q[backplane_ctrl_pkg::SEL_PAR_B01] |=> (par_out[39:32] == $past(par_in[47:40])))
        else $error("Data of b1 not steered onto b0");

    parity_sense_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ((^{par_out[7:0], par_parity[0]}) == !$past(parity_even)))
        else $error("Parallel parity sense wrong");

    min_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
        (fifo_level[4:0] < min_thr_q[4:0]) |=> threshold_alarm[0])
        else $error("Minimum threshold alarm missing");

    max_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
        (fifo_level[39:35] > max_thr_q[4:0]) |=> threshold_alarm[7])
        else $error("Maximum threshold alarm missing");

    sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (set_v != 8'h00) |=> ((status_q & $past(set_v)) == $past(set_v)))
        else $error("Alarm event lost against a clear");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (|(status_q & irq_mask_q)) |=> irq)
        else $error("Interrupt not raised");

    arm_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        (arm[0] && ctrl_q[3:0] != 4'h0) |=> ins_busy[0])
        else $error("Insert command did not start");

    cover_write_c: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_sel);
    cover_alarm_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    cover_odd_c: cover property (@(posedge pclk) disable iff (!presetn) !parity_even);
    cover_strobe_c: cover property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready_q && pwrite && !pstrb[0]);
    cover_insert_c: cover property (@(posedge pclk) disable iff (!presetn)
        ins_busy[0] && tx_first_fb[0]);

endmodule

// ### backplane_ctrl_pkg.sv
// Purpose: Shared constants for the backplane channel control registers.
// Assumes: APB register words, one register per aligned word, byte address = 4 * index.
// Notes: Channel numbering is a0..a3 = 0..3 and b0..b3 = 4..7.
package backplane_ctrl_pkg;

    localparam int NUM_CH = 8;
    localparam int BYTE_W = 8;
    localparam int LVL_W = 5;
    localparam int CNT_W = 4;
    localparam int IDX_W = 20;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices.
    localparam logic [IDX_W-1:0] IDX_PAIR_SEL = 20'h3_0009;
    localparam logic [IDX_W-1:0] IDX_MIN_THR = 20'h3_000a;
    localparam logic [IDX_W-1:0] IDX_MAX_THR = 20'h3_000b;
    localparam logic [IDX_W-1:0] IDX_CTRL = 20'h3_000c;
    localparam logic [IDX_W-1:0] IDX_FB1_VAL = 20'h3_000d;
    localparam logic [IDX_W-1:0] IDX_FB2_VAL = 20'h3_000e;
    localparam logic [IDX_W-1:0] IDX_INS_CMD = 20'h3_0040;
    localparam logic [IDX_W-1:0] IDX_ALM_STATUS = 20'h3_0041;
    localparam logic [IDX_W-1:0] IDX_ALM_LATCH_EN = 20'h3_0042;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 20'h3_0043;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [7:0] RST_PAIR_SEL = 8'hff;
    localparam logic [7:0] RST_MIN_THR = 8'h40;
    localparam logic [7:0] RST_MAX_THR = 8'ha8;
    localparam logic [7:0] RST_CTRL = 8'h60;
    localparam logic [7:0] RST_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int SEL_TOH_A01 = 0;
    localparam int SEL_TOH_A23 = 1;
    localparam int SEL_PAR_A01 = 2;
    localparam int SEL_PAR_A23 = 3;
    localparam int SEL_TOH_B01 = 4;
    localparam int SEL_TOH_B23 = 5;
    localparam int SEL_PAR_B01 = 6;
    localparam int SEL_PAR_B23 = 7;
    localparam int THR_MSB = 4;
    localparam int CNT_MSB = 3;
    localparam int CTRL_LOOPBACK = 4;
    localparam int CTRL_PARITY = 5;
    localparam int CTRL_SCRAMBLE = 6;

    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_ANSWER = 1'b1
    } apb_state_e;

endpackage

// ### fabric_model.sv
// Purpose: Fabric-side model driving the parallel, overhead and transmit byte streams.
// Assumes: Frames are four bytes long and every channel frames together.
// Notes: Stream bytes stay below 8'h40 so they never match the substitute values.
`timescale 1ns/1ps
module fabric_model #(
    parameter logic [63:0] PAR = 64'h0000_0000_0000_0000,
    parameter logic [7:0] TOH = 8'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic [7:0] toh_in,
    output logic [63:0] par_in,
    output logic [63:0] tx_data_in,
    output logic [7:0] tx_frame_start,
    output logic [7:0] tx_first_fb,
    output logic [7:0] tx_second_fb
);
    ////////////////////////////////////////
    logic [5:0] step_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= 6'h00;
        end else begin
            step_q <= step_q + 6'h01;
        end
    end
    assign toh_in = TOH;
    assign par_in = PAR;
    assign tx_data_in = {8{2'b00, step_q}};
    // The frame start and the first framing byte must coincide.
    assign tx_frame_start = {8{step_q[1:0] == 2'b00}};
    assign tx_first_fb = tx_frame_start;
    assign tx_second_fb = {8{step_q[1:0] == 2'b01}};
endmodule

// ### fb_error_insert.sv
// Purpose: Per-channel framing-byte corruption on the transmit byte stream.
// Assumes: frame_start marks the first framing byte of each frame.
// Notes: The output byte is registered, so the stream is delayed by one cycle.
`timescale 1ns/1ps
module fb_error_insert (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic arm,
    input wire logic [3:0] count,
    input wire logic [7:0] fb1_val,
    input wire logic [7:0] fb2_val,
    input wire logic [7:0] data_in,
    input wire logic frame_start,
    input wire logic first_fb,
    input wire logic second_fb,
    output logic [7:0] data_out_q,
    output logic busy
);

    logic [3:0] remaining_q;
    logic corrupt_q;
    logic corrupt_now;

    // The frame decision is taken on the frame's own first byte, so it must be combinational.
    assign corrupt_now = frame_start ? (remaining_q != 4'h0) : corrupt_q;
    assign busy = (remaining_q != 4'h0) || corrupt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remaining_q <= 4'h0;
            corrupt_q <= 1'b0;
        end else if (arm) begin
            remaining_q <= count;
            corrupt_q <= 1'b0;
        end else if (frame_start) begin
            corrupt_q <= (remaining_q != 4'h0);
            if (remaining_q != 4'h0) begin
                remaining_q <= remaining_q - 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out_q <= 8'h00;
        end else if (corrupt_now && first_fb) begin
            data_out_q <= fb1_val;
        end else if (corrupt_now && second_fb) begin
            data_out_q <= fb2_val;
        end else begin
            data_out_q <= data_in;
        end
    end

endmodule

// ### pair_output_select.sv
// Purpose: Pair steering of overhead serial and parallel data outputs, with parity.
// Assumes: Channels 0, 2, 4 and 6 may take the next channel's stream.
// Notes: All outputs are registered; one cycle of latency from input to output.
`timescale 1ns/1ps
module pair_output_select (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] sel,
    input wire logic parity_even,
    input wire logic [7:0] toh_in,
    input wire logic [63:0] par_in,
    output logic [7:0] toh_out_q,
    output logic [63:0] par_out_q,
    output logic [7:0] par_parity_q
);

    genvar i;
    generate
        for (i = 0; i < backplane_ctrl_pkg::NUM_CH; i++) begin : g_ch
            localparam int TOH_BIT = (i == 0) ? backplane_ctrl_pkg::SEL_TOH_A01 :
                                     (i == 2) ? backplane_ctrl_pkg::SEL_TOH_A23 :
                                     (i == 4) ? backplane_ctrl_pkg::SEL_TOH_B01 :
                                     backplane_ctrl_pkg::SEL_TOH_B23;
            localparam int PAR_BIT = (i == 0) ? backplane_ctrl_pkg::SEL_PAR_A01 :
                                     (i == 2) ? backplane_ctrl_pkg::SEL_PAR_A23 :
                                     (i == 4) ? backplane_ctrl_pkg::SEL_PAR_B01 :
                                     backplane_ctrl_pkg::SEL_PAR_B23;
            logic toh_src;
            logic [7:0] par_src;
            if (i % 2 == 0) begin : g_pair
                assign toh_src = sel[TOH_BIT] ? toh_in[i] : toh_in[i+1];
                assign par_src = sel[PAR_BIT] ? par_in[i*8 +: 8] : par_in[(i+1)*8 +: 8];
            end else begin : g_own
                assign toh_src = toh_in[i];
                assign par_src = par_in[i*8 +: 8];
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    toh_out_q[i] <= 1'b0;
                    par_out_q[i*8 +: 8] <= 8'h00;
                    par_parity_q[i] <= 1'b0;
                end else begin
                    toh_out_q[i] <= toh_src;
                    par_out_q[i*8 +: 8] <= par_src;
                    par_parity_q[i] <= parity_even ? (^par_src) : ~(^par_src);
                end
            end
        end
    endgenerate

endmodule

// ### tb.sv
// Purpose: Self-checking bench for the backplane channel control registers.
// Assumes: APB master tasks; the bench plays the alignment FIFO levels.
// Notes: Expected mux outputs are rebuilt from the select byte and parity sense.
`timescale 1ns/1ps
module tb;
    localparam logic [63:0] PAR = 64'h8877_6655_4433_2211;
    localparam logic [7:0] TOH = 8'h55;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [39:0] fifo_level = {8{5'h0a}};
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, err, loopback_en, scramble_en, parity_even;
    logic [7:0] threshold_alarm, toh_in, toh_out, par_parity, fs, f1, f2;
    logic [63:0] par_in, par_out, tx_in, tx_out;
    logic [79:0] e;
    int bad_count = 0;
    int samples_checked = 0;
    int n1, n2, n3;
    initial forever #4 pclk = ~pclk;
    fabric_model #(.PAR(PAR), .TOH(TOH)) fab (.pclk(pclk), .presetn(presetn),
        .toh_in(toh_in), .par_in(par_in), .tx_data_in(tx_in), .tx_frame_start(fs),
        .tx_first_fb(f1), .tx_second_fb(f2));
    backplane_channel_control_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .fifo_level(fifo_level), .threshold_alarm(threshold_alarm), .toh_in(toh_in),
        .toh_out(toh_out), .par_in(par_in), .par_out(par_out), .par_parity(par_parity),
        .tx_data_in(tx_in), .tx_frame_start(fs), .tx_first_fb(f1), .tx_second_fb(f2),
        .tx_data_out(tx_out), .loopback_en(loopback_en), .scramble_en(scramble_en),
        .parity_even(parity_even));
    ////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Every call starts just after a rising edge and returns one edge after the answer.
    task automatic apb(input logic w, input logic [19:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {10'h000, idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input string what, input logic [19:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(what, {32'h0, rd}, {56'h0, exp});
    endtask
    // Returns parity, overhead and parallel outputs expected for a select byte.
    function automatic logic [79:0] mux_exp(input logic [7:0] s, input logic even);
        logic [63:0] p;
        logic [7:0] t, q;
        p = PAR;
        t = TOH;
        for (int c = 0; c < 8; c += 2) begin
            if (!s[(c / 4) * 4 + (c / 2) % 2]) t[c] = TOH[c + 1];
            if (!s[(c / 4) * 4 + (c / 2) % 2 + 2]) p[c * 8 +: 8] = PAR[(c + 1) * 8 +: 8];
        end
        for (int c = 0; c < 8; c++) q[c] = even ? ^p[c * 8 +: 8] : ~^p[c * 8 +: 8];
        return {q, t, p};
    endfunction
    task automatic mux_chk(input logic [7:0] s, input logic even);
        repeat (2) @(posedge pclk);
        e = mux_exp(s, even);
        check("par_out", par_out, e[63:0]);
        check("toh_out", {56'h0, toh_out}, {56'h0, e[71:64]});
        check("par_parity", {56'h0, par_parity}, {56'h0, e[79:72]});
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("ctrl outs", {61'h0, loopback_en, scramble_en, parity_even}, 64'h3);
        rdchk("pair_sel", backplane_ctrl_pkg::IDX_PAIR_SEL, 8'hff);
        rdchk("min_thr", backplane_ctrl_pkg::IDX_MIN_THR, 8'h40);
        rdchk("max_thr", backplane_ctrl_pkg::IDX_MAX_THR, 8'ha8);
        rdchk("ctrl", backplane_ctrl_pkg::IDX_CTRL, 8'h60);
        rdchk("fb1", backplane_ctrl_pkg::IDX_FB1_VAL, 8'h00);
        rdchk("fb2", backplane_ctrl_pkg::IDX_FB2_VAL, 8'h00);
        pstrb <= 4'he;
        apb(1'b1, backplane_ctrl_pkg::IDX_FB1_VAL, 8'h77);
        pstrb <= 4'hf;
        rdchk("fb1 lane off", backplane_ctrl_pkg::IDX_FB1_VAL, 8'h00);
        apb(1'b0, 20'h0_0000, 8'h00);
        check("unmapped", {63'h0, err}, 64'h1);
        $display("test reset_and_map done");
        for (int b = 0; b < 8; b++) begin
            apb(1'b1, backplane_ctrl_pkg::IDX_PAIR_SEL, ~(8'h01 << b));
            mux_chk(~(8'h01 << b), 1'b1);
        end
        apb(1'b1, backplane_ctrl_pkg::IDX_PAIR_SEL, 8'h00);
        apb(1'b1, backplane_ctrl_pkg::IDX_CTRL, 8'h50);
        mux_chk(8'h00, 1'b0);
        check("ctrl outs", {61'h0, loopback_en, scramble_en, parity_even}, 64'h6);
        apb(1'b1, backplane_ctrl_pkg::IDX_CTRL, 8'h20);
        check("ctrl outs", {61'h0, loopback_en, scramble_en, parity_even}, 64'h1);
        $display("test steering done");
        apb(1'b1, backplane_ctrl_pkg::IDX_MIN_THR, 8'h05);
        apb(1'b1, backplane_ctrl_pkg::IDX_MAX_THR, 8'h14);
        rdchk("max_thr", backplane_ctrl_pkg::IDX_MAX_THR, 8'h14);
        fifo_level <= {5'd10, 5'd10, 5'd10, 5'd10, 5'd20, 5'd5, 5'd21, 5'd4};
        repeat (3) @(posedge pclk);
        check("alarm", {56'h0, threshold_alarm}, 64'h03);
        apb(1'b1, backplane_ctrl_pkg::IDX_ALM_LATCH_EN, 8'hff);
        fifo_level <= {8{5'd10}};
        rdchk("status", backplane_ctrl_pkg::IDX_ALM_STATUS, 8'h03);
        check("irq masked", {63'h0, irq}, 64'h0);
        apb(1'b1, backplane_ctrl_pkg::IDX_IRQ_MASK, 8'h02);
        repeat (2) @(posedge pclk);
        check("irq", {63'h0, irq}, 64'h1);
        apb(1'b1, backplane_ctrl_pkg::IDX_ALM_STATUS, 8'h03);
        rdchk("status", backplane_ctrl_pkg::IDX_ALM_STATUS, 8'h00);
        check("irq cleared", {63'h0, irq}, 64'h0);
        $display("test thresholds done");
        apb(1'b1, backplane_ctrl_pkg::IDX_FB1_VAL, 8'ha5);
        apb(1'b1, backplane_ctrl_pkg::IDX_FB2_VAL, 8'h5a);
        apb(1'b1, backplane_ctrl_pkg::IDX_CTRL, 8'h62);
        apb(1'b1, backplane_ctrl_pkg::IDX_INS_CMD, 8'h01);
        n1 = 0;
        n2 = 0;
        n3 = 0;
        repeat (40) begin
            @(posedge pclk);
            if (tx_out[7:0] === 8'ha5) n1++;
            if (tx_out[7:0] === 8'h5a) n2++;
            if (tx_out[15:8] === 8'ha5) n3++;
        end
        check("fb1 frames", 64'(n1), 64'h2);
        check("fb2 frames", 64'(n2), 64'h2);
        check("other channel", 64'(n3), 64'h0);
        rdchk("busy", backplane_ctrl_pkg::IDX_INS_CMD, 8'h00);
        $display("test error_insert done");
        summarize();
    end
endmodule
